// ===== rtl/dtm_regs.svh
// register offsets, field positions, reset values and timing counts of the drive trip monitor
// assumes a 100 MHz system clock and a 32-bit avalon-mm slave port with byte addresses
// Function
// - encoder selected as feedback and no feedback signal raises encoder trip
// - current control mode: field current below 6% of rated flags field loss
// - voltage control mode: field current below 50mA flags field loss
// - field loss must persist 1 second before the trip; shorter never trips (code counts 10000 ticks of 100us, so it can trip up to one tick short)
// - field supply disabled suppresses the field loss trip entirely
// - total or single phase loss of the three-phase supply raises supply trip
// - supply frequency outside 45 to 65 hertz raises the mains sync trip
// - invalid frame on the peer serial port raises the peer link trip
// - peer link trip armed only in peer follower mode
// - at standstill, current above stall limit longer than stall time trips
// - stall enable off keeps stall timer and stall trip inactive
// - current feedback above 280% of rated raises the overcurrent trip
// - 300% up to 15ms or 325% up to 6.6ms must not trip
`ifndef DTM_REGS_SVH
`define DTM_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define DTM_OFS_CTRL 8'h00
`define DTM_OFS_RATED_FIELD 8'h04
`define DTM_OFS_RATED_ARM 8'h08
`define DTM_OFS_STALL_LIMIT 8'h0c
`define DTM_OFS_STALL_DELAY 8'h10
`define DTM_OFS_TRIP 8'h14
`define DTM_OFS_IRQ_STATUS 8'h18
`define DTM_OFS_IRQ_MASK 8'h1c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DTM_CTRL_FIELD_EN 0
`define DTM_CTRL_FIELD_VMODE 1
`define DTM_CTRL_STALL_EN 2
`define DTM_CTRL_FOLLOWER 3
`define DTM_CTRL_FBK_LO 4
`define DTM_CTRL_FBK_HI 5
`define DTM_CTRL_CLEAR 8
`define DTM_CTRL_RESET 9'h001
`define DTM_FBK_ENCODER 2'h2

// ----------------------------------------------------------------
// reset values and trip thresholds
// ----------------------------------------------------------------
`define DTM_RATED_FIELD_RESET 16'h03e8
`define DTM_RATED_ARM_RESET 16'h2710
`define DTM_STALL_LIMIT_RESET 16'h2710
`define DTM_STALL_DELAY_RESET 16'h2710
`define DTM_FIELD_LOSS_PCT 32'd6
`define DTM_FIELD_LOSS_MA 16'd50
`define DTM_OVER_PCT 32'd280
`define DTM_OVER_HIGH_PCT 32'd325
`define DTM_FREQ_MIN_DHZ 16'd450
`define DTM_FREQ_MAX_DHZ 16'd650

// ----------------------------------------------------------------
// timing: sample tick and trip delays
// ----------------------------------------------------------------
`define DTM_CLK_NS 10
`define DTM_TICK_NS 100000
`define DTM_TICK_CYCLES (`DTM_TICK_NS / `DTM_CLK_NS)
`define DTM_FIELD_DELAY_MS 1000
`define DTM_FIELD_DELAY_TICKS ((`DTM_FIELD_DELAY_MS * 1000000) / `DTM_TICK_NS)
`define DTM_OVER_LONG_US 15000
`define DTM_OVER_LONG_TICKS ((`DTM_OVER_LONG_US * 1000) / `DTM_TICK_NS)
`define DTM_OVER_SHORT_US 6600
`define DTM_OVER_SHORT_TICKS ((`DTM_OVER_SHORT_US * 1000) / `DTM_TICK_NS)

`endif

// ===== rtl/dtm_pkg.sv
// types shared by the drive trip monitor
// assumes dtm_regs.svh holds all numeric constants
`default_nettype none
package dtm_pkg;
    // first-trip code; none means no trip latched
    typedef enum logic [3:0] {
        DTM_NONE,
        DTM_ENCODER,
        DTM_FIELD,
        DTM_SUPPLY,
        DTM_SYNC,
        DTM_PEER,
        DTM_STALL,
        DTM_OVER
    } dtm_code_e;
    typedef logic [6:0] dtm_trips_t;
endpackage : dtm_pkg
`default_nettype wire

// ===== rtl/dtm_top.sv
// drive trip monitor: qualifies fault conditions, latches trips, avalon-mm registers
// assumes measurement values and peer frame strobes come from logic on clk
`timescale 1ns/10ps
`default_nettype none
`include "dtm_regs.svh"

module dtm_top #(
    parameter int TICK_CYCLES = `DTM_TICK_CYCLES,
    parameter int FIELD_DELAY_TICKS = `DTM_FIELD_DELAY_TICKS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic encoder_present,
    input wire logic [2:0] phase_present,
    input wire logic [15:0] field_current_ma,
    input wire logic [15:0] armature_current,
    input wire logic [15:0] supply_freq_dhz,
    input wire logic peer_frame_done,
    input wire logic peer_frame_bad,
    input wire logic standstill_flag,
    output var dtm_pkg::dtm_trips_t trips,
    output var dtm_pkg::dtm_code_e first_trip,
    output logic trip_any,
    output logic irq
);
    import dtm_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sync1_q, sync2_q;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            // pins reset to their present level so no false trip follows reset
            sync1_q <= 4'hf;
            sync2_q <= 4'hf;
        end else begin
            sync1_q <= {encoder_present, phase_present};
            sync2_q <= sync1_q;
        end
    end

    // ----------------------------------------------------------------
    // registers and bus state
    // ----------------------------------------------------------------
    logic [8:0] ctrl_q, ctrl_d;
    logic [15:0] rated_field_q, rated_field_d, rated_arm_q, rated_arm_d;
    logic [15:0] stall_limit_q, stall_limit_d, stall_delay_q, stall_delay_d;
    logic [6:0] irq_status_q, irq_status_d, irq_mask_q, irq_mask_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] wmask;
    logic wr_go, rd_go, clear_go;

    // ----------------------------------------------------------------
    // sample tick and trip state
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;
    logic [31:0] field_cnt_q, field_cnt_d;
    logic [15:0] stall_cnt_q, stall_cnt_d;
    logic [15:0] over_cnt_q, over_cnt_d;
    dtm_trips_t cause, trip_q, trip_d;
    dtm_code_e first_q, first_d;
    logic any_q, any_d, irq_q, irq_d;
    logic field_low, field_cond, stall_cond, over_cond, over_high;
    logic field_trip, stall_trip, over_trip;
    logic [31:0] field_x100, arm_x100, rated_field_x6, rated_arm_x280, rated_arm_x325;

    always_comb begin
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        // the request is taken on the edge where waitrequest is already low
        wr_go = avs_write && !wait_q;
        rd_go = avs_read && !wait_q;
        clear_go = wr_go && (avs_address == `DTM_OFS_CTRL) && wmask[`DTM_CTRL_CLEAR]
                   && avs_writedata[`DTM_CTRL_CLEAR];
    end

    // ----------------------------------------------------------------
    // fault conditions
    // ----------------------------------------------------------------
    always_comb begin
        field_x100 = 32'(field_current_ma) * 32'd100;
        arm_x100 = 32'(armature_current) * 32'd100;
        rated_field_x6 = 32'(rated_field_q) * `DTM_FIELD_LOSS_PCT;
        rated_arm_x280 = 32'(rated_arm_q) * `DTM_OVER_PCT;
        rated_arm_x325 = 32'(rated_arm_q) * `DTM_OVER_HIGH_PCT;
        if (ctrl_q[`DTM_CTRL_FIELD_VMODE]) begin
            field_low = field_current_ma < `DTM_FIELD_LOSS_MA;
        end else begin
            field_low = field_x100 < rated_field_x6;
        end
        field_cond = field_low && ctrl_q[`DTM_CTRL_FIELD_EN];
        stall_cond = ctrl_q[`DTM_CTRL_STALL_EN] && standstill_flag
                     && (armature_current > stall_limit_q);
        over_cond = arm_x100 > rated_arm_x280;
        over_high = arm_x100 > rated_arm_x325;
        field_trip = field_cnt_q >= 32'(FIELD_DELAY_TICKS);
        stall_trip = stall_cond && (stall_cnt_q > stall_delay_q);
        over_trip = over_cond && ((over_high && over_cnt_q > 16'(`DTM_OVER_SHORT_TICKS))
                    || over_cnt_q > 16'(`DTM_OVER_LONG_TICKS));
        cause[0] = (ctrl_q[`DTM_CTRL_FBK_HI:`DTM_CTRL_FBK_LO] == `DTM_FBK_ENCODER)
                   && !sync2_q[3];
        cause[1] = field_trip && field_cond;
        cause[2] = !(&sync2_q[2:0]);
        cause[3] = (supply_freq_dhz < `DTM_FREQ_MIN_DHZ)
                   || (supply_freq_dhz > `DTM_FREQ_MAX_DHZ);
        cause[4] = ctrl_q[`DTM_CTRL_FOLLOWER] && peer_frame_done && peer_frame_bad;
        cause[5] = stall_trip;
        cause[6] = over_trip;
    end

    // ----------------------------------------------------------------
    // delay counters
    // ----------------------------------------------------------------
    always_comb begin
        tick_d = tick_cnt_q == 32'(TICK_CYCLES - 1);
        tick_cnt_d = tick_d ? 32'h0 : tick_cnt_q + 32'h1;
        field_cnt_d = !field_cond ? 32'h0 :
                      (tick_q && !field_trip) ? field_cnt_q + 32'h1 : field_cnt_q;
        stall_cnt_d = !stall_cond ? 16'h0 :
                      (tick_q && stall_cnt_q != 16'hffff) ? stall_cnt_q + 16'h1 : stall_cnt_q;
        over_cnt_d = !over_cond ? 16'h0 :
                     (tick_q && over_cnt_q != 16'hffff) ? over_cnt_q + 16'h1 : over_cnt_q;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
            field_cnt_q <= 32'h0;
            stall_cnt_q <= 16'h0;
            over_cnt_q <= 16'h0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
            field_cnt_q <= field_cnt_d;
            stall_cnt_q <= stall_cnt_d;
            over_cnt_q <= over_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // trip latches and first-trip code
    // ----------------------------------------------------------------
    always_comb begin
        trip_d = trip_q | cause;
        if (clear_go) begin
            // a clear only drops trips whose cause is gone
            trip_d = cause | (trip_q & cause);
        end
        first_d = first_q;
        if (first_q == DTM_NONE || trip_q == 7'h0) begin
            first_d = DTM_NONE;
            for (int i = 6; i >= 0; i--) begin
                if (trip_d[i]) begin
                    first_d = dtm_code_e'(4'(i + 1));
                end
            end
        end
        if (trip_d == 7'h0) begin
            first_d = DTM_NONE;
        end
        any_d = |trip_d;
    end

    // ----------------------------------------------------------------
    // interrupt status, read-to-clear; a new event wins over the clear
    // ----------------------------------------------------------------
    always_comb begin
        irq_status_d = irq_status_q;
        if (rd_go && avs_address == `DTM_OFS_IRQ_STATUS) begin
            // only bits handed out in the read data clear; a later event survives
            irq_status_d = irq_status_q & ~rdata_q[6:0];
        end
        irq_status_d = irq_status_d | (trip_d & ~trip_q);
        irq_d = |(irq_status_d & irq_mask_d);
    end

    // ----------------------------------------------------------------
    // avalon-mm slave: one wait cycle, then the request is taken
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        ctrl_d[`DTM_CTRL_CLEAR] = 1'b0;
        rated_field_d = rated_field_q;
        rated_arm_d = rated_arm_q;
        stall_limit_d = stall_limit_q;
        stall_delay_d = stall_delay_q;
        irq_mask_d = irq_mask_q;
        // waitrequest drops for exactly one cycle per request
        wait_d = !((avs_read || avs_write) && wait_q);
        rdata_d = rdata_q;
        if (wr_go) begin
            unique case (avs_address)
                `DTM_OFS_CTRL: begin
                    ctrl_d[5:0] = (ctrl_q[5:0] & ~wmask[5:0]) | (avs_writedata[5:0] & wmask[5:0]);
                end
                `DTM_OFS_RATED_FIELD: begin
                    rated_field_d = (rated_field_q & ~wmask[15:0])
                                    | (avs_writedata[15:0] & wmask[15:0]);
                end
                `DTM_OFS_RATED_ARM: begin
                    rated_arm_d = (rated_arm_q & ~wmask[15:0])
                                  | (avs_writedata[15:0] & wmask[15:0]);
                end
                `DTM_OFS_STALL_LIMIT: begin
                    stall_limit_d = (stall_limit_q & ~wmask[15:0])
                                    | (avs_writedata[15:0] & wmask[15:0]);
                end
                `DTM_OFS_STALL_DELAY: begin
                    stall_delay_d = (stall_delay_q & ~wmask[15:0])
                                    | (avs_writedata[15:0] & wmask[15:0]);
                end
                `DTM_OFS_IRQ_MASK: begin
                    irq_mask_d = (irq_mask_q & ~wmask[6:0]) | (avs_writedata[6:0] & wmask[6:0]);
                end
                default: begin
                end
            endcase
        end
        if (avs_read && wait_q) begin
            unique case (avs_address)
                `DTM_OFS_CTRL: rdata_d = {26'h0, ctrl_q[5:0]};
                `DTM_OFS_RATED_FIELD: rdata_d = {16'h0, rated_field_q};
                `DTM_OFS_RATED_ARM: rdata_d = {16'h0, rated_arm_q};
                `DTM_OFS_STALL_LIMIT: rdata_d = {16'h0, stall_limit_q};
                `DTM_OFS_STALL_DELAY: rdata_d = {16'h0, stall_delay_q};
                `DTM_OFS_TRIP: rdata_d = {20'h0, first_q, 1'b0, trip_q};
                `DTM_OFS_IRQ_STATUS: rdata_d = {25'h0, irq_status_q};
                `DTM_OFS_IRQ_MASK: rdata_d = {25'h0, irq_mask_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q <= `DTM_CTRL_RESET;
            rated_field_q <= `DTM_RATED_FIELD_RESET;
            rated_arm_q <= `DTM_RATED_ARM_RESET;
            stall_limit_q <= `DTM_STALL_LIMIT_RESET;
            stall_delay_q <= `DTM_STALL_DELAY_RESET;
            irq_status_q <= 7'h0;
            irq_mask_q <= 7'h0;
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
            trip_q <= 7'h0;
            first_q <= DTM_NONE;
            any_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            rated_field_q <= rated_field_d;
            rated_arm_q <= rated_arm_d;
            stall_limit_q <= stall_limit_d;
            stall_delay_q <= stall_delay_d;
            irq_status_q <= irq_status_d;
            irq_mask_q <= irq_mask_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            trip_q <= trip_d;
            first_q <= first_d;
            any_q <= any_d;
            irq_q <= irq_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign trips = trip_q;
    assign first_trip = first_q;
    assign trip_any = any_q;
    assign irq = irq_q;
endmodule : dtm_top

`default_nettype wire

// ===== testbench/dtm_peer_model.sv
// peer drive model: sends one frame per request on the peer serial port
// assumes send is a one-cycle pulse from the bench, launched on clk
`timescale 1ns/10ps
`default_nettype none
module dtm_peer_model (
    input wire logic clk,
    input wire logic send,
    input wire logic bad,
    output logic frame_done = 1'b0,
    output logic frame_bad = 1'b0
);
    logic idle_q = 1'b0;
    // the qualifier means nothing outside a frame, so it wanders there
    always @(posedge clk) begin
        idle_q <= ~idle_q;
        frame_done <= send;
        frame_bad <= send ? bad : idle_q;
    end
endmodule : dtm_peer_model
`default_nettype wire

// ===== testbench/dtm_top_properties.sv
// checker for the drive trip monitor: trip timing and latching at its ports
// assumes rated field and armature settings keep their reset values
`timescale 1ns/10ps
`default_nettype none
module dtm_top_properties #(
    parameter int TICK_CYCLES = 10000,
    parameter int FIELD_DELAY_TICKS = 10000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic [2:0] phase_present,
    input wire logic [15:0] field_current_ma,
    input wire logic [15:0] armature_current,
    input wire logic [15:0] supply_freq_dhz,
    input wire logic peer_frame_done,
    input wire logic peer_frame_bad,
    input wire logic standstill_flag,
    input wire dtm_pkg::dtm_trips_t trips,
    input wire dtm_pkg::dtm_code_e first_trip,
    input wire logic trip_any
);
    import dtm_pkg::*;
    // ----------------------------------------------------------------
    // hold counters: cycles each cause has stood unbroken
    // ----------------------------------------------------------------
    int ovc_q, ovc_d, fld_q, fld_d;
    logic clr_w;
    assign clr_w = avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_writedata[8];
    always_comb begin
        ovc_d = (armature_current > 16'd28000) ? ovc_q + 1 : 0;
        fld_d = (field_current_ma < 16'd60) ? fld_q + 1 : 0;
    end
    always_ff @(posedge clk) begin
        ovc_q <= resetn ? ovc_d : 0;
        fld_q <= resetn ? fld_d : 0;
    end
    default clocking dflt_cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_phase_gone; (phase_present != 3'h7) [*3]; endsequence
    sequence s_freq_out; supply_freq_dhz < 16'd450 || supply_freq_dhz > 16'd650; endsequence
    property p_sync; s_freq_out |=> trips[3]; endproperty
    a_sync: assert property (p_sync) else $error("sync trip missing");
    property p_supply; s_phase_gone |=> trips[2]; endproperty
    a_supply: assert property (p_supply) else $error("supply trip missing");
    // lower bound only: tick phase makes the exact cycle loose
    property p_over_min; $rose(trips[6]) |-> ovc_q >= 66 * TICK_CYCLES; endproperty
    a_over_min: assert property (p_over_min) else $error("overcurrent too early");
    property p_over_max; ovc_q > 153 * TICK_CYCLES |-> trips[6]; endproperty
    a_over_max: assert property (p_over_max) else $error("overcurrent missing");
    property p_field; $rose(trips[1]) |-> fld_q >= (FIELD_DELAY_TICKS - 1) * TICK_CYCLES; endproperty
    a_field: assert property (p_field) else $error("field trip too early");
    property p_latch; (!clr_w) [*3] |=> (trips & $past(trips)) == $past(trips); endproperty
    a_latch: assert property (p_latch) else $error("trip dropped uncleared");
    property p_first; trip_any |=> !trip_any || $stable(first_trip); endproperty
    a_first: assert property (p_first) else $error("first code moved");
    property p_peer; $rose(trips[4]) |-> $past(peer_frame_done && peer_frame_bad); endproperty
    a_peer: assert property (p_peer) else $error("peer trip without bad frame");
    property p_stall; $rose(trips[5]) |-> $past(standstill_flag); endproperty
    a_stall: assert property (p_stall) else $error("stall trip while moving");
endmodule : dtm_top_properties
bind dtm_top dtm_top_properties #(
    .TICK_CYCLES(TICK_CYCLES),
    .FIELD_DELAY_TICKS(FIELD_DELAY_TICKS)
) prop_u (
    .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .phase_present(phase_present), .field_current_ma(field_current_ma),
    .armature_current(armature_current), .supply_freq_dhz(supply_freq_dhz),
    .peer_frame_done(peer_frame_done), .peer_frame_bad(peer_frame_bad),
    .standstill_flag(standstill_flag), .trips(trips), .first_trip(first_trip),
    .trip_any(trip_any)
);
`default_nettype wire

// ===== testbench/drive_trip_monitor_tb_top.sv
// self-checking bench for the drive trip monitor with an integer trip model
// assumes the peer model and the bound checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
module drive_trip_monitor_tb_top;
    import dtm_pkg::*;
    localparam int TC = 10;
    localparam int FD = 20;
    logic clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, enc = 1'b1;
    logic send = 1'b0, bad = 1'b0, still = 1'b0, done_w, bad_w, wait_w, any_w, irq_w;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, v;
    logic [2:0] ph = 3'h7;
    logic [15:0] fld = 16'd1000, arm = 16'h0, frq = 16'd500;
    dtm_trips_t trips;
    dtm_code_e first;
    int miscompares = 0, compares = 0, ctrl = 1;
    logic [15:0] fq[4] = '{16'd449, 16'd450, 16'd650, 16'd651};
    logic [2:0] pv[4] = '{3'h6, 3'h5, 3'h3, 3'h0};
    int ad[8] = '{0, 4, 8, 12, 16, 20, 28, 32};
    int rv[8] = '{1, 1000, 10000, 10000, 10000, 0, 0, 0};
    int rc[15] = '{1, 1, 1, 3, 3, 0, 5, 5, 5, 1, 5, 1, 1, 1, 1};
    int rs[15] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 1, 1, 0, 0, 0, 0};
    int rt[15] = '{25, 15, 15, 25, 25, 25, 8, 3, 8, 8, 8, 140, 160, 60, 75};
    int rf[15], ra[15];
    dtm_peer_model peer_u (
        .clk(clk), .send(send), .bad(bad), .frame_done(done_w), .frame_bad(bad_w)
    );
    dtm_top #(.TICK_CYCLES(TC), .FIELD_DELAY_TICKS(FD)) dut_u (
        .clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(wait_w), .encoder_present(enc), .phase_present(ph),
        .field_current_ma(fld), .armature_current(arm), .supply_freq_dhz(frq),
        .peer_frame_done(done_w), .peer_frame_bad(bad_w), .standstill_flag(still),
        .trips(trips), .first_trip(first), .trip_any(any_w), .irq(irq_w)
    );
    // ----------------------------------------------------------------
    // model, bus and check tasks
    // ----------------------------------------------------------------
    function automatic int exp_bit(int c, int st, int f, int a, int t);
        if (a > 28000 && (t > 150 || (a > 32500 && t > 66))) return 6;
        if (c[2] && st != 0 && a > 10000 && t > 6) return 5;
        if (c[0] && f < (c[1] ? 50 : 60) && t > FD) return 1;
        return -1;
    endfunction : exp_bit
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // called on a rising edge; the request stands until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (wait_w !== 1'b0);
        v = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        // one idle edge so the next call never re-raises a strobe in this step
        @(posedge clk);
    endtask : bus
    task automatic expect_trip(input int b);
        repeat (4) @(posedge clk);
        chk(trips, (b < 0) ? 0 : 1 << b);
        chk(first, b + 1);
        chk({irq_w, any_w}, {1'b0, b >= 0});
        enc <= 1'b1;
        ph <= 3'h7;
        fld <= 16'd1000;
        arm <= 16'h0;
        frq <= 16'd500;
        still <= 1'b0;
        repeat (3) @(posedge clk);
        bus(1'b1, 8'h00, ctrl | 32'h100);
        repeat (2) @(posedge clk);
        chk(trips, 0);
    endtask : expect_trip
    task automatic end_of_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        v = $urandom(32'hda0cc594);
        rf = '{$urandom_range(59, 0), $urandom_range(59, 0), $urandom_range(59, 0), 55,
            $urandom_range(49, 0), 0, 1000, 1000, 1000, 1000, 1000, 1000, 1000, 1000, 1000};
        ra = '{0, 0, 0, 0, 0, 0, $urandom_range(27999, 10001), 12000, 12000, 12000, 10000,
            30000, $urandom_range(32500, 28001), 33000, $urandom_range(60000, 32501)};
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk({wait_w, any_w, irq_w, trips}, 10'h200);
        bus(1'b1, 8'h20, 32'hffffffff);
        bus(1'b1, 8'h14, 32'hffffffff);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, ad[i][7:0], 0);
            chk(v, rv[i]);
        end
        bus(1'b1, 8'h1c, 32'h8);
        frq <= 16'd651;
        repeat (4) @(posedge clk);
        chk(irq_w, 1'b1);
        bus(1'b1, 8'h00, 32'h101);
        bus(1'b0, 8'h14, 0);
        chk(v, 32'h408);
        bus(1'b0, 8'h18, 0);
        chk(v, 32'h8);
        bus(1'b0, 8'h18, 0);
        chk(v, 32'h0);
        bus(1'b1, 8'h1c, 0);
        expect_trip(3);
        foreach (fq[i]) begin
            frq <= fq[i];
            expect_trip((fq[i] < 450 || fq[i] > 650) ? 3 : -1);
        end
        foreach (pv[i]) begin
            ph <= pv[i];
            expect_trip(2);
        end
        for (int s = 0; s < 4; s++) begin
            ctrl = 1 | (s << 4);
            bus(1'b1, 8'h00, ctrl);
            enc <= 1'b0;
            expect_trip((s == 2) ? 0 : -1);
        end
        for (int s = 0; s < 4; s++) begin
            ctrl = 1 | ((s >> 1) << 3);
            bus(1'b1, 8'h00, ctrl);
            send <= 1'b1;
            bad <= s[0];
            @(posedge clk);
            send <= 1'b0;
            expect_trip((s == 3) ? 4 : -1);
        end
        bus(1'b1, 8'h10, 32'h5);
        for (int i = 0; i < 15; i++) begin
            ctrl = rc[i];
            bus(1'b1, 8'h00, ctrl);
            still <= rs[i][0];
            fld <= rf[i][15:0];
            arm <= ra[i][15:0];
            repeat (rt[i] * TC) @(posedge clk);
            expect_trip(exp_bit(rc[i], rs[i], rf[i], ra[i], rt[i]));
        end
        end_of_test();
    end
endmodule : drive_trip_monitor_tb_top
`default_nettype wire
